// ===== pkg/ncc_cfg.svh
/*
  Constants of the network controller command bank: register offsets,
  command bit positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef NCC_CFG_SVH
`define NCC_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define NCC_OFS_CMD 12'h000
`define NCC_OFS_FDP 12'h004
`define NCC_OFS_RRP 12'h008
`define NCC_OFS_WDT 12'h00C
`define NCC_OFS_STAT 12'h010
`define NCC_OFS_TALLY 12'h014

// ------------------------------------------------------------
// Command bit positions
// ------------------------------------------------------------
`define NCC_BIT_LOAD 9
`define NCC_BIT_FETCH 8
`define NCC_BIT_SRST 7
`define NCC_BIT_START 5
`define NCC_BIT_STOP 4
`define NCC_BIT_TXP 1
`define NCC_CMD_WMASK 16'h03BF

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define NCC_CMD_RESET 16'h0080
`define NCC_FETCH_CYCLES 4'h4
`define NCC_LOAD_CYCLES 4'h8

`endif

// ===== pkg/ncc_pkg.sv
/*
  Types of the network controller command bank.
  Assumes the constants header is on the include path.
*/
package ncc_pkg;
  `include "ncc_cfg.svh"

  typedef enum logic [1:0] {
    NCC_IDLE = 2'b00,
    NCC_LOAD = 2'b01,
    NCC_FETCH = 2'b10
  } ncc_seq_t;
endpackage

// ===== verilog/ncc_wdog.sv
/*
  General-purpose watchdog counter with start and stop control.
  Assumes run comes from the command bank and load from a write of the timer register.
*/
`timescale 1ns/1ps
module ncc_wdog
  import ncc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Async reset, low
  input wire logic run, // Count enable
  input wire logic load, // Load new value
  input wire logic [15:0] loadVal, // Value to load
  output logic [15:0] count // Present count
);
  typedef struct packed {
    logic [15:0] count;
  } ncc_wd_t;

  ncc_wd_t st, next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = loadVal;
    end else if (run) begin
      next_st.count = st.count - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

  a_wd_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!run && !load) |=> $stable(count))
    else $error("watchdog moved while halted");
endmodule

// ===== verilog/ncc_tally.sv
/*
  Tally counter for received frame events, halted but kept in soft reset.
  Assumes event is a one-cycle pulse from the receive logic.
*/
`timescale 1ns/1ps
module ncc_tally
  import ncc_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Async reset, low
  input wire logic halt, // Hold the count
  input wire logic evt, // Event pulse
  output logic [15:0] count // Present count
);
  typedef struct packed {
    logic [15:0] count;
  } ncc_ty_t;

  ncc_ty_t st, next_st;

  always_comb begin
    next_st = st;
    if (evt && !halt) begin
      next_st.count = st.count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

  a_tally_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
    halt |=> count == $past(count))
    else $error("tally changed during soft reset");
endmodule

// ===== verilog/ncc_cmd_bank.sv
/*
  Command register bank on APB with filter load and resource fetch
  sequencers, software reset, watchdog control and a tally counter.
  Assumes a single-word memory port that answers combinationally in the
  request cycle and an APB master that keeps to the protocol.
*/
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module ncc_cmd_bank
  import ncc_pkg::*;
(
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rst_b, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic memReq, // Memory read request
  output logic [31:0] memAddr, // Memory read address
  input wire logic [31:0] memData, // Memory read data, same cycle as request
  output logic camWe, // Match memory write pulse
  output logic [2:0] camIdx, // Match memory entry index
  output logic [31:0] camData, // Match memory entry data
  output logic [31:0] rraWord, // Last resource word read
  output logic crcEnable, // Frame check generator enable
  output logic smReset, // Internal machines held in reset
  input wire logic rxEvent // Tally event pulse
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cmd;
    logic [31:0] fdp;
    logic [31:0] resource_read_pointer;
    ncc_seq_t seq;
    logic [3:0] cnt;
    logic memReq;
    logic [31:0] memAddr;
    logic camWe;
    logic [2:0] camIdx;
    logic [31:0] camData;
    logic [31:0] rraWord;
    logic [31:0] prdata;
    logic pslverr;
  } ncc_st_t;

  ncc_st_t st, next_st;
  logic [15:0] wdCount;
  logic [15:0] tallyCount;
  logic wdLoad;
  logic access;
  logic setup;
  logic wrCmd;
  logic srst;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign access = psel && penable;
  // Read data is registered in setup so it stands through the access cycle
  assign setup = psel && !penable;
  assign wrCmd = access && pwrite && hit(paddr, `NCC_OFS_CMD);
  assign wdLoad = access && pwrite && hit(paddr, `NCC_OFS_WDT);
  assign srst = st.cmd[`NCC_BIT_SRST];

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] w;
    logic mapped;
    w = '0;
    mapped = 1'b0;
    next_st = st;
    next_st.memReq = 1'b0;
    next_st.camWe = 1'b0;
    if (setup) begin
      mapped = hit(paddr, `NCC_OFS_CMD) || hit(paddr, `NCC_OFS_FDP) ||
               hit(paddr, `NCC_OFS_RRP) || hit(paddr, `NCC_OFS_WDT) ||
               hit(paddr, `NCC_OFS_STAT) || hit(paddr, `NCC_OFS_TALLY);
      next_st.pslverr = !mapped;
      next_st.prdata = '0;
      if (!pwrite) begin
        if (hit(paddr, `NCC_OFS_CMD)) next_st.prdata = {16'h0000, st.cmd};
        if (hit(paddr, `NCC_OFS_FDP)) next_st.prdata = st.fdp;
        if (hit(paddr, `NCC_OFS_RRP)) next_st.prdata = st.resource_read_pointer;
        if (hit(paddr, `NCC_OFS_WDT)) next_st.prdata = {16'h0000, wdCount};
        if (hit(paddr, `NCC_OFS_STAT)) next_st.prdata = st.rraWord;
        if (hit(paddr, `NCC_OFS_TALLY)) next_st.prdata = {16'h0000, tallyCount};
      end
    end
    if (access && pwrite) begin
      if (hit(paddr, `NCC_OFS_FDP)) next_st.fdp = pwdata;
      if (hit(paddr, `NCC_OFS_RRP)) next_st.resource_read_pointer = pwdata;
    end
    if (wrCmd) begin
      // Reserved bits are dropped so they always read zero
      w = pwdata[15:0] & `NCC_CMD_WMASK;
      next_st.cmd[`NCC_BIT_SRST] = w[`NCC_BIT_SRST];
      next_st.cmd[`NCC_BIT_TXP] = w[`NCC_BIT_TXP];
      if (w[`NCC_BIT_LOAD]) next_st.cmd[`NCC_BIT_LOAD] = 1'b1;
      if (w[`NCC_BIT_FETCH]) next_st.cmd[`NCC_BIT_FETCH] = 1'b1;
      // Stop wins if both are written, leaving the timer halted
      if (w[`NCC_BIT_START]) begin
        next_st.cmd[`NCC_BIT_START] = 1'b1;
        next_st.cmd[`NCC_BIT_STOP] = 1'b0;
      end
      if (w[`NCC_BIT_STOP]) begin
        next_st.cmd[`NCC_BIT_STOP] = 1'b1;
        next_st.cmd[`NCC_BIT_START] = 1'b0;
      end
    end
    // ------------------------------------------------------------
    // Sequencers, held idle by software reset
    // ------------------------------------------------------------
    if (srst) begin
      next_st.seq = NCC_IDLE;
      next_st.cnt = '0;
    end else begin
      unique case (st.seq)
        NCC_IDLE: begin
          // Load has priority; a pending fetch waits its turn
          if (st.cmd[`NCC_BIT_LOAD]) begin
            next_st.seq = NCC_LOAD;
            next_st.cnt = '0;
            next_st.memReq = 1'b1;
            next_st.memAddr = st.fdp;
          end else if (st.cmd[`NCC_BIT_FETCH]) begin
            next_st.seq = NCC_FETCH;
            next_st.cnt = '0;
            next_st.memReq = 1'b1;
            next_st.memAddr = st.resource_read_pointer;
          end
        end
        NCC_LOAD: begin
          next_st.camWe = 1'b1;
          next_st.camIdx = st.cnt[2:0];
          next_st.camData = memData;
          if (st.cnt == `NCC_LOAD_CYCLES - 4'h1) begin
            next_st.seq = NCC_IDLE;
            next_st.cmd[`NCC_BIT_LOAD] = 1'b0;
            next_st.fdp = st.fdp + 32'h0000_0020;
          end else begin
            next_st.cnt = st.cnt + 4'h1;
            next_st.memReq = 1'b1;
            next_st.memAddr = st.memAddr + 32'h0000_0004;
          end
        end
        NCC_FETCH: begin
          next_st.rraWord = memData;
          if (st.cnt == `NCC_FETCH_CYCLES - 4'h1) begin
            next_st.seq = NCC_IDLE;
            next_st.cmd[`NCC_BIT_FETCH] = 1'b0;
            next_st.resource_read_pointer = st.resource_read_pointer + 32'h0000_0010;
          end else begin
            next_st.cnt = st.cnt + 4'h1;
            next_st.memReq = 1'b1;
            next_st.memAddr = st.memAddr + 32'h0000_0004;
          end
        end
        default: next_st.seq = NCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.cmd <= `NCC_CMD_RESET;
      st.seq <= NCC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs and submodules
  // ------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr && access;
  assign memReq = st.memReq;
  assign memAddr = st.memAddr;
  assign camWe = st.camWe;
  assign camIdx = st.camIdx;
  assign camData = st.camData;
  assign rraWord = st.rraWord;
  assign smReset = srst;
  assign crcEnable = !srst;

  ncc_wdog u_wdog (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(st.cmd[`NCC_BIT_START] && !srst),
    .load(wdLoad),
    .loadVal(pwdata[15:0]),
    .count(wdCount)
  );

  ncc_tally u_tally (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .halt(srst),
    .evt(rxEvent),
    .count(tallyCount)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_start_clears_stop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wrCmd && pwdata[5] && !pwdata[4]) |=> (st.cmd[5] && !st.cmd[4]))
    else $error("start did not clear stop");
  a_stop_clears_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wrCmd && pwdata[4]) |=> (st.cmd[4] && !st.cmd[5]))
    else $error("stop did not clear start");
  a_one_of_two: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(st.cmd[5] && st.cmd[4]))
    else $error("start and stop both set");
  a_srst_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    srst |=> st.seq == NCC_IDLE && !camWe)
    else $error("sequencer active in soft reset");
  a_crc_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    crcEnable == !st.cmd[7])
    else $error("frame check not tied to soft reset");
  a_srst_sticks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (srst && !wrCmd) |=> srst)
    else $error("soft reset left without a write");
  a_load_starts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st.cmd[9] && !srst && st.seq == NCC_IDLE) |=> memReq && memAddr == $past(st.fdp))
    else $error("filter load did not fetch at pointer");
  a_load_burst: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st.seq == NCC_IDLE ##1 st.seq == NCC_LOAD && !srst) |-> ##1 camWe)
    else $error("match entry not written");
  a_fetch_starts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!st.cmd[9] && st.cmd[8] && !srst && st.seq == NCC_IDLE)
      |=> memReq && memAddr == $past(st.resource_read_pointer))
    else $error("resource fetch did not read at pointer");
  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st.cmd & ~`NCC_CMD_WMASK) == 16'h0000)
    else $error("reserved command bit set");

  c_load_done: cover property (@(posedge sys_clk) disable iff (!rst_b)
    st.seq == NCC_LOAD ##1 st.seq == NCC_IDLE);
  c_fetch_done: cover property (@(posedge sys_clk) disable iff (!rst_b)
    st.seq == NCC_FETCH ##1 st.seq == NCC_IDLE);
  c_timer_run: cover property (@(posedge sys_clk) disable iff (!rst_b)
    st.cmd[5] && !srst);
  c_srst_exit: cover property (@(posedge sys_clk) disable iff (!rst_b)
    srst ##1 !srst);
endmodule

// ===== tb/ncc_cmd_bank_tb_top.sv
/*
  Self-checking bench of the command bank: APB master tasks, a memory
  responder and one scenario task per behaviour.
  Assumes the constants header on the include path and zero-wait APB.
*/
`timescale 1ns/1ps
`include "ncc_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin nMismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ncc_cmd_bank_tb_top;
  import ncc_pkg::*;
  logic sysClk, rstB, psel, penable, pwrite, pready, pslverr, memReq, camWe;
  logic crcEnable, smReset, rxEvent, errSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, memAddr, memData, camData, rraWord, rd, held;
  logic [2:0] camIdx;
  logic [2:0] camIdxLog [0:15];
  logic [31:0] camDataLog [0:15];
  int nCam, nMismatch, comparisons;
  // ------------------------------------------------------------
  // Device and surroundings
  // ------------------------------------------------------------
  ncc_cmd_bank u_ncc_cmd_bank (.sys_clk(sysClk), .rst_b(rstB), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
    .memAddr(memAddr), .memData(memData), .camWe(camWe), .camIdx(camIdx),
    .camData(camData), .rraWord(rraWord), .crcEnable(crcEnable),
    .smReset(smReset), .rxEvent(rxEvent));
  function automatic logic [31:0] memPat(input logic [31:0] a);
    return a ^ 32'hA5C3_0000;
  endfunction
  initial begin
    sysClk = 1'b0;
    forever #10 sysClk = ~sysClk;
  end
  // Memory answers in the request cycle; idle data is inverted so a stray sample fails
  assign memData = (memReq === 1'b1) ? memPat(memAddr) : ~memPat(memAddr);
  always @(posedge sysClk) begin
    if (camWe === 1'b1 && nCam < 16) begin
      camIdxLog[nCam] = camIdx;
      camDataLog[nCam] = camData;
      nCam++;
    end
  end
  // ------------------------------------------------------------
  // Bus and event tasks
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int n;
    @(posedge sysClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sysClk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) nMismatch++;
    // Answer is taken at the edge that samples pready high
    q = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] q;
    apb(1'b1, a, wd, q);
  endtask
  task automatic pulse_rx(input int n);
    repeat (n) begin
      @(posedge sysClk);
      rxEvent <= 1'b1;
      @(posedge sysClk);
      rxEvent <= 1'b0;
    end
  endtask
  task automatic wait_cmd_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `NCC_OFS_CMD, 32'h0, rd);
      n++;
    end while (rd[9:8] !== 2'b00 && n < 40);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_state();
    apb(1'b0, `NCC_OFS_CMD, 32'h0, rd);
    `CHK(rd, 32'h0000_0080)
    `CHK(smReset, 1'b1)
    `CHK(crcEnable, 1'b0)
  endtask
  task automatic t_soft_reset();
    pulse_rx(2);
    apb(1'b0, `NCC_OFS_TALLY, 32'h0, rd);
    `CHK(rd, 32'h0)
    wr(`NCC_OFS_CMD, 32'h0);
    @(negedge sysClk);
    `CHK(smReset, 1'b0)
    `CHK(crcEnable, 1'b1)
    pulse_rx(3);
    wr(`NCC_OFS_CMD, 32'h0080);
    @(negedge sysClk);
    `CHK(smReset, 1'b1)
    `CHK(crcEnable, 1'b0)
    pulse_rx(4);
    apb(1'b0, `NCC_OFS_TALLY, 32'h0, rd);
    `CHK(rd, 32'h3)
    wr(`NCC_OFS_CMD, 32'h0);
  endtask
  task automatic t_timer();
    wr(`NCC_OFS_WDT, 32'h0100);
    wr(`NCC_OFS_CMD, 32'h0020);
    repeat (10) @(posedge sysClk);
    wr(`NCC_OFS_CMD, 32'h0010);
    apb(1'b0, `NCC_OFS_CMD, 32'h0, rd);
    `CHK(rd, 32'h0000_0010)
    apb(1'b0, `NCC_OFS_WDT, 32'h0, held);
    `CHK(held < 32'h0100, 1'b1)
    repeat (10) @(posedge sysClk);
    apb(1'b0, `NCC_OFS_WDT, 32'h0, rd);
    `CHK(rd, held)
    wr(`NCC_OFS_CMD, 32'h0020);
    apb(1'b0, `NCC_OFS_CMD, 32'h0, rd);
    `CHK(rd, 32'h0000_0020)
    repeat (5) @(posedge sysClk);
    apb(1'b0, `NCC_OFS_WDT, 32'h0, rd);
    `CHK(rd < held && rd > held - 32'h40, 1'b1)
    // Both written together: stop is taken
    wr(`NCC_OFS_CMD, 32'h0030);
    apb(1'b0, `NCC_OFS_CMD, 32'h0, rd);
    `CHK(rd, 32'h0000_0010)
    wr(`NCC_OFS_CMD, 32'h0);
  endtask
  task automatic t_filter_load();
    nCam = 0;
    wr(`NCC_OFS_FDP, 32'h0000_1000);
    wr(`NCC_OFS_CMD, 32'h0200);
    wait_cmd_idle();
    `CHK(rd[9], 1'b0)
    `CHK(nCam, 8)
    for (int k = 0; k < 8; k++) begin
      `CHK(camIdxLog[k], 3'(k))
      `CHK(camDataLog[k], memPat(32'h1000 + 32'(4 * k)))
    end
    apb(1'b0, `NCC_OFS_FDP, 32'h0, rd);
    `CHK(rd, 32'h0000_1020)
  endtask
  task automatic t_resource_fetch();
    nCam = 0;
    wr(`NCC_OFS_RRP, 32'h0000_2000);
    wr(`NCC_OFS_CMD, 32'h0100);
    wait_cmd_idle();
    `CHK(rd[8], 1'b0)
    `CHK(rraWord, memPat(32'h200C))
    apb(1'b0, `NCC_OFS_STAT, 32'h0, rd);
    `CHK(rd, memPat(32'h200C))
    apb(1'b0, `NCC_OFS_RRP, 32'h0, rd);
    `CHK(rd, 32'h0000_2010)
    `CHK(nCam, 0)
    // Unmapped place leaves the bank untouched
    wr(12'h020, 32'hFFFF_FFFF);
    `CHK(errSeen, 1'b1)
    apb(1'b0, `NCC_OFS_CMD, 32'h0, rd);
    `CHK(errSeen, 1'b0)
    // Stop bit is still set from the timer scenario
    `CHK(rd, 32'h0000_0010)
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rstB = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rxEvent = 1'b0;
    nCam = 0;
    nMismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge sysClk);
    rstB <= 1'b1;
    t_reset_state();
    t_soft_reset();
    t_timer();
    t_filter_load();
    t_resource_fetch();
    report_and_stop();
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (20000) @(posedge sysClk);
    nMismatch++;
    report_and_stop();
  end
endmodule
